// ===== hdl/twb_pkg.sv
// Package of constants, APB register map and types for the two-wire bus block
// Behaviour
// - First byte: 7-bit address, direction bit
// - Receiver acknowledges with SDA low
// - Master: START, address, bytes, acks, STOP
// - Transmitter drives byte, receiver drives acknowledge
// - Lines only pulled low or released
// - Master starts only on free bus
// - Lost SDA while master: become slave
// - Master waits for SCL actually high
// - Timeout timer reloads high, counts low
// - Bus free after ten idle source periods
// - Pending START issued on free timeout
// - Byte interrupt after ack tx, before rx
// - Interrupt on START sent, slave STOP
// - Enable bit enables master and slave
// - Inhibit: NACK addresses, no slave interrupts
// - Inhibit takes effect at next START
// - Two-bit select picks overflow source
// - Source used as master or free timeout
// - Master SCL low, high at least one period
// - Typical bit rate one third overflow rate
package twb_pkg;
  localparam logic [11:0] TWB_CFG_OFS = 12'h000;
  localparam logic [11:0] TWB_CTL_OFS = 12'h004;
  localparam logic [11:0] TWB_DAT_OFS = 12'h008;
  localparam logic [11:0] TWB_ADR_OFS = 12'h00c;
  // Configuration bit positions
  localparam int TWB_CFG_EN = 7;
  localparam int TWB_CFG_INH = 6;
  localparam int TWB_CFG_BUSY = 5;
  localparam int TWB_CFG_TOE = 3;
  localparam int TWB_CFG_FTE = 2;
  // Control bit positions
  localparam int TWB_CTL_MASTER = 7;
  localparam int TWB_CTL_TXMODE = 6;
  localparam int TWB_CTL_STA = 5;
  localparam int TWB_CTL_STO = 4;
  localparam int TWB_CTL_ACKRQ = 3;
  localparam int TWB_CTL_ARBLOST = 2;
  localparam int TWB_CTL_ACK = 1;
  localparam int TWB_CTL_SI = 0;
  localparam logic [7:0] TWB_CFG_RST = 8'h00;
  localparam logic [7:0] TWB_CTL_RST = 8'h00;
  localparam logic [6:0] TWB_OWN_ADDR_RST = 7'h00;
  localparam logic [3:0] TWB_FREE_PERIODS = 4'ha;
  localparam logic [1:0] TWB_LOW_PERIODS = 2'h1;
  localparam logic [1:0] TWB_HIGH_PERIODS = 2'h2;
  typedef struct packed {
    logic scl;
    logic sda;
  } twb_line_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_START = 7'h02,
    ST_BIT = 7'h04,
    ST_WAIT = 7'h08,
    ST_ACK = 7'h10,
    ST_STOP = 7'h20,
    ST_SLV = 7'h40
  } twb_state_t;
endpackage : twb_pkg

// ===== hdl/twb_ctrl.sv
// Two-wire bus controller, master and slave, with APB register access
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module twb_ctrl
  import twb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] TMR_OVF,
  output logic TOUT_RELOAD,
  output logic IRQ,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE,
  output logic SDA_O,
  output logic SDA_OE
);
  // Two-flop synchronisers on pins and timer overflows
  twb_line_t s1_reg, s2_reg, s3_reg;
  logic [3:0] t1_reg, t2_reg, t3_reg;
  always_ff @(posedge CLK_SYS) begin
    s1_reg <= '{scl: SCL_I, sda: SDA_I};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    t1_reg <= TMR_OVF;
    t2_reg <= t1_reg;
    t3_reg <= t2_reg;
  end
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] dat_reg, dat_next;
  logic [6:0] own_reg, own_next;
  twb_state_t st_reg, st_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] free_reg, free_next;
  logic busy_reg, busy_next;
  logic inh_reg, inh_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic rx_reg, rx_next;
  logic [31:0] prd_reg, prd_next;
  logic rdy_reg, rdy_next;
  logic tick, start_det, stop_det, scl_rise, scl_fall, en;
  logic wr, rd, idle_hi, addr_match;
  // Source overflow picked by two select bits
  assign tick = t2_reg[cfg_reg[1:0]] & ~t3_reg[cfg_reg[1:0]];
  assign scl_rise = s2_reg.scl & ~s3_reg.scl;
  assign scl_fall = ~s2_reg.scl & s3_reg.scl;
  assign start_det = s3_reg.scl & s2_reg.scl & s3_reg.sda & ~s2_reg.sda;
  assign stop_det = s3_reg.scl & s2_reg.scl & ~s3_reg.sda & s2_reg.sda;
  assign en = cfg_reg[TWB_CFG_EN];
  assign idle_hi = s2_reg.scl & s2_reg.sda;
  assign wr = PSEL & PENABLE & PWRITE & ~rdy_reg;
  assign rd = PSEL & PENABLE & ~PWRITE & ~rdy_reg;
  assign addr_match = (dat_reg[7:1] == own_reg);
  // Register, bus state and shifter next values
  always_comb begin
    cfg_next = cfg_reg;
    ctl_next = ctl_reg;
    dat_next = dat_reg;
    own_next = own_reg;
    st_next = st_reg;
    bit_next = bit_reg;
    ph_next = ph_reg;
    free_next = free_reg;
    busy_next = busy_reg;
    inh_next = inh_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    rx_next = rx_reg;
    prd_next = 32'h0000_0000;
    rdy_next = PSEL & PENABLE & ~rdy_reg;
    // Bus busy tracking and free timeout
    if (start_det) begin
      busy_next = 1'b1;
      inh_next = cfg_reg[TWB_CFG_INH];
    end
    if (!idle_hi || !cfg_reg[TWB_CFG_FTE]) begin
      free_next = 4'h0;
    end else if (tick && free_reg != TWB_FREE_PERIODS) begin
      free_next = free_reg + 4'h1;
    end
    if (stop_det) begin
      busy_next = 1'b0;
    end else if (tick && idle_hi && free_reg == TWB_FREE_PERIODS) begin
      busy_next = 1'b0;
    end
    unique case (st_reg)
      ST_IDLE: begin
        scl_next = 1'b1;
        sda_next = 1'b1;
        ph_next = 2'h0;
        // Pending START waits for a free bus
        if (ctl_reg[TWB_CTL_STA] && !busy_reg && !ctl_reg[TWB_CTL_SI]) begin
          st_next = ST_START;
          sda_next = 1'b0;
          busy_next = 1'b1;
        end else if (start_det) begin
          st_next = ST_SLV;
          bit_next = 3'h7;
          rx_next = 1'b1;
          ctl_next[TWB_CTL_MASTER] = 1'b0;
        end
      end
      ST_START: begin
        // SDA held low until the next tick, then SCL falls
        if (tick) begin
          scl_next = 1'b0;
          st_next = ST_WAIT;
          ctl_next[TWB_CTL_MASTER] = 1'b1;
          ctl_next[TWB_CTL_TXMODE] = 1'b1;
          ctl_next[TWB_CTL_STA] = 1'b0;
          ctl_next[TWB_CTL_SI] = 1'b1;
          rx_next = 1'b0;
        end
      end
      ST_WAIT: begin
        // Software holds the bus with SCL low until it clears the flag
        if (!ctl_reg[TWB_CTL_SI]) begin
          if (ctl_reg[TWB_CTL_STO]) begin
            st_next = ST_STOP;
            sda_next = 1'b0;
            ph_next = 2'h0;
          end else begin
            st_next = ST_BIT;
            bit_next = 3'h7;
            ph_next = 2'h0;
            rx_next = ~ctl_reg[TWB_CTL_TXMODE];
            sda_next = ctl_reg[TWB_CTL_TXMODE] ? dat_reg[7] : 1'b1;
          end
        end
      end
      ST_BIT, ST_ACK: begin
        // One tick low, wait for real high, two ticks high
        if (ph_reg == 2'h0) begin
          if (tick) begin
            scl_next = 1'b1;
            ph_next = 2'h1;
          end
        end else if (ph_reg == 2'h1) begin
          if (s2_reg.scl) begin
            ph_next = 2'h2;
          end
        end else if (ph_reg == 2'h2) begin
          if (tick) begin
            ph_next = 2'h3;
          end
        end else if (tick) begin
          scl_next = 1'b0;
          ph_next = 2'h0;
          if (st_reg == ST_BIT) begin
            dat_next = {dat_reg[6:0], s2_reg.sda};
            if (bit_reg == 3'h0) begin
              st_next = ST_ACK;
              // Receiver: interrupt before acknowledge
              sda_next = rx_reg ? ~ctl_reg[TWB_CTL_ACK] : 1'b1;
              if (rx_reg) begin
                ctl_next[TWB_CTL_SI] = 1'b1;
                ctl_next[TWB_CTL_ACKRQ] = 1'b1;
                st_next = ST_WAIT;
                sda_next = 1'b1;
              end
            end else begin
              bit_next = bit_reg - 3'h1;
              sda_next = rx_reg ? 1'b1 : dat_reg[6];
            end
          end else begin
            // Transmitter: interrupt after acknowledge seen
            sda_next = 1'b1;
            st_next = ST_WAIT;
            ctl_next[TWB_CTL_SI] = 1'b1;
            if (!rx_reg) begin
              ctl_next[TWB_CTL_ACK] = ~s2_reg.sda;
            end
          end
        end
        // Released SDA seen low while sending: arbitration lost
        if (st_reg == ST_BIT && !rx_reg && ph_reg == 2'h2 && sda_reg &&
            !s2_reg.sda) begin
          st_next = ST_SLV;
          scl_next = 1'b1;
          sda_next = 1'b1;
          bit_next = bit_reg;
          ctl_next[TWB_CTL_MASTER] = 1'b0;
          ctl_next[TWB_CTL_ARBLOST] = 1'b1;
          ctl_next[TWB_CTL_SI] = 1'b1;
        end
      end
      ST_STOP: begin
        // SCL released first, then SDA rises while SCL high
        if (tick) begin
          if (ph_reg == 2'h0) begin
            scl_next = 1'b1;
            ph_next = 2'h1;
          end else if (s2_reg.scl) begin
            sda_next = 1'b1;
            st_next = ST_IDLE;
            ctl_next[TWB_CTL_STO] = 1'b0;
            ctl_next[TWB_CTL_MASTER] = 1'b0;
          end
        end
      end
      ST_SLV: begin
        // Slave address receive, answered per inhibit state
        if (scl_rise) begin
          dat_next = {dat_reg[6:0], s2_reg.sda};
        end
        if (scl_fall) begin
          if (sda_reg == 1'b0) begin
            sda_next = 1'b1;
            bit_next = 3'h7;
          end else if (bit_reg == 3'h0) begin
            if (addr_match && !inh_reg && rx_reg) begin
              sda_next = 1'b0;
              ctl_next[TWB_CTL_SI] = 1'b1;
              ctl_next[TWB_CTL_TXMODE] = dat_reg[0];
            end
            rx_next = 1'b0;
          end else begin
            bit_next = bit_reg - 3'h1;
          end
        end
        if (stop_det) begin
          st_next = ST_IDLE;
          if (!inh_reg && !rx_reg) begin
            ctl_next[TWB_CTL_SI] = 1'b1;
          end
        end else if (!busy_reg) begin
          // Free timeout ends an abandoned frame so a pending START can go
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // APB writes; software may clear the flag only while it is set, so a hardware set of a clear flag in the same cycle is kept
    if (wr && PADDR == TWB_CFG_OFS) begin
      cfg_next = PWDATA[7:0] & 8'hdf;
    end
    if (wr && PADDR == TWB_CTL_OFS) begin
      ctl_next[TWB_CTL_STA] = PWDATA[TWB_CTL_STA];
      ctl_next[TWB_CTL_STO] = PWDATA[TWB_CTL_STO];
      ctl_next[TWB_CTL_ACK] = PWDATA[TWB_CTL_ACK];
      if (!PWDATA[TWB_CTL_SI] && !ctl_next[TWB_CTL_SI] == 1'b0 &&
          ctl_reg[TWB_CTL_SI]) begin
        ctl_next[TWB_CTL_SI] = 1'b0;
        ctl_next[TWB_CTL_ACKRQ] = 1'b0;
        ctl_next[TWB_CTL_ARBLOST] = 1'b0;
      end
    end
    if (wr && PADDR == TWB_DAT_OFS) begin
      dat_next = PWDATA[7:0];
    end
    if (wr && PADDR == TWB_ADR_OFS) begin
      own_next = PWDATA[6:0];
    end
    if (rd) begin
      unique case (PADDR)
        TWB_CFG_OFS: prd_next = {24'h0, cfg_reg[7:6], busy_reg, cfg_reg[4:0]};
        TWB_CTL_OFS: prd_next = {24'h0, ctl_reg};
        TWB_DAT_OFS: prd_next = {24'h0, dat_reg};
        TWB_ADR_OFS: prd_next = {25'h0, own_reg};
        default: prd_next = 32'h0000_0000;
      endcase
    end
    // Disable drops the frame, busy and control flags and frees the lines
    if (!en) begin
      st_next = ST_IDLE;
      scl_next = 1'b1;
      sda_next = 1'b1;
      busy_next = 1'b0;
      free_next = 4'h0;
      ctl_next = TWB_CTL_RST;
    end
  end
  // All state registers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cfg_reg <= TWB_CFG_RST;
      ctl_reg <= TWB_CTL_RST;
      dat_reg <= 8'h00;
      own_reg <= TWB_OWN_ADDR_RST;
      st_reg <= ST_IDLE;
      bit_reg <= 3'h7;
      ph_reg <= 2'h0;
      free_reg <= 4'h0;
      busy_reg <= 1'b0;
      inh_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rx_reg <= 1'b0;
      prd_reg <= 32'h0000_0000;
      rdy_reg <= 1'b0;
      TOUT_RELOAD <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      ctl_reg <= ctl_next;
      dat_reg <= dat_next;
      own_reg <= own_next;
      st_reg <= st_next;
      bit_reg <= bit_next;
      ph_reg <= ph_next;
      free_reg <= free_next;
      busy_reg <= busy_next;
      inh_reg <= inh_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      rx_reg <= rx_next;
      prd_reg <= prd_next;
      rdy_reg <= rdy_next;
      TOUT_RELOAD <= ~cfg_reg[TWB_CFG_TOE] | s2_reg.scl;
      // Follows the flag's next value so it drops with a disable
      IRQ <= ctl_next[TWB_CTL_SI];
    end
  end
  // Open-drain outputs: only ever drive low
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = ~scl_reg;
  assign SDA_OE = ~sda_reg;
  assign PRDATA = prd_reg;
  assign PREADY = rdy_reg;
  assign PSLVERR = 1'b0;
endmodule : twb_ctrl
`default_nettype wire

// ===== tb/twb_monitor.sv
// Port timing checker for the two-wire bus controller
`timescale 1ns/100ps
`default_nettype none
module twb_monitor (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SDA_O,
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic TOUT_RELOAD,
  input wire logic IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Access still waiting, flag pending with clock pulled
  sequence s_wait; PSEL && PENABLE && !PREADY; endsequence
  sequence s_held; IRQ && SCL_OE; endsequence
  property p_answer; s_wait |=> PREADY; endproperty
  a_answer: assert property (p_answer) else $error("ready late");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_no_err; PSEL |-> !PSLVERR; endproperty
  a_no_err: assert property (p_no_err) else $error("error flagged");
  property p_drain; SCL_OE || SDA_OE |-> !SCL_O && !SDA_O; endproperty
  a_drain: assert property (p_drain) else $error("line driven high");
  property p_rel_hi; SCL_I [*4] |=> TOUT_RELOAD; endproperty
  a_rel_hi: assert property (p_rel_hi) else $error("no reload");
  property p_rel_lo;
    !TOUT_RELOAD |-> !$past(SCL_I, 2) || !$past(SCL_I, 3);
  endproperty
  a_rel_lo: assert property (p_rel_lo) else $error("bad count");
  property p_rst_free; $fell(SRST) |-> !SCL_OE && !SDA_OE; endproperty
  a_rst_free: assert property (p_rst_free) else $error("lines held");
  // Clock stays low while software owns the byte
  property p_held; s_held |=> SCL_OE || !IRQ; endproperty
  a_held: assert property (p_held) else $error("clock freed");
endmodule : twb_monitor
`default_nettype wire

// ===== tb/twb_peer.sv
// Behavioural slave on the shared two-wire bus
`timescale 1ns/100ps
`default_nettype none
module twb_peer #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] last,
  output logic stopped
);
  logic [7:0] sh;
  logic hit;
  logic first;
  logic again;
  // Frame follower; pulls low or lets go, never drives high
  initial begin
    scl_oe = 0;
    sda_oe = 0;
    stopped = 1;
    last = 0;
    again = 0;
    forever begin
      if (!again) @(negedge sda iff scl === 1'b1);
      again = 0;
      stopped = 0;
      first = 1;
      hit = 0;
      fork
        @(posedge sda iff scl === 1'b1);
        // Repeated START restarts the frame count
        begin
          @(negedge sda iff scl === 1'b1);
          again = 1;
        end
        forever begin
          repeat (8) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
          end
          @(negedge scl);
          if (first) hit = sh[7:1] == ADDR;
          first = 0;
          last = sh;
          sda_oe = hit;
          @(negedge scl);
          sda_oe = 0;
          // Stretch low phase so the master has to wait
          scl_oe = hit;
          #200 scl_oe = 0;
        end
      join_any
      disable fork;
      stopped = 1;
      sda_oe = 0;
      scl_oe = 0;
    end
  end
endmodule : twb_peer
`default_nettype wire

// ===== tb/twb_ctrl_bench.sv
// Self-checking bench for the two-wire bus controller
`timescale 1ns/100ps
`default_nettype none
module twb_ctrl_bench;
  import twb_pkg::*;
  logic clk, srst, psel, penable, pwrite, tb_scl, scl_oe, sda_oe;
  logic p_scl, p_sda, pready, reload, irq, stopped, tb_sda;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] ovf;
  logic [2:0] oc;
  logic [1:0] sel;
  logic [7:0] rx;
  int mismatches, checked, cyc, pc;
  // Pull-up wires: low while any party pulls
  wire scl = !(scl_oe | p_scl | tb_scl);
  wire sda = !(sda_oe | p_sda | tb_sda);
  twb_ctrl i_dut (.CLK_SYS(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .TMR_OVF(ovf),
    .TOUT_RELOAD(reload), .IRQ(irq), .SCL_I(scl), .SDA_I(sda),
    .SCL_O(), .SCL_OE(scl_oe), .SDA_O(), .SDA_OE(sda_oe));
  twb_peer i_peer (.scl(scl), .sda(sda), .scl_oe(p_scl),
    .sda_oe(p_sda), .last(rx), .stopped(stopped));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Source kept running; one pulse in eight cycles on the chosen bit
  always @(posedge clk) begin
    oc <= oc + 3'h1;
    ovf <= (oc == 3'h7) ? 4'h1 << sel : 4'h0;
    pc <= pc + int'(oc == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize;
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; request held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    chk("pready", pready, 1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Skips the launch edge so a stale flag is not taken
  task wirq;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 4000);
    chk("irq", irq, 1);
  endtask : wirq
  task t_regs;
    apb(0, TWB_CFG_OFS, 0);
    chk("cfg", q, {24'h0, TWB_CFG_RST});
    apb(0, TWB_CTL_OFS, 0);
    chk("ctl", q, {24'h0, TWB_CTL_RST});
    apb(1, TWB_ADR_OFS, 32'h15);
    apb(0, TWB_ADR_OFS, 0);
    chk("adr", q, 32'h15);
    apb(1, 12'h010, 32'hff);
    apb(0, 12'h010, 0);
    chk("void", q, 0);
    apb(1, TWB_CFG_OFS, 32'h20);
    apb(0, TWB_CFG_OFS, 0);
    chk("busy", q, 0);
  endtask : t_regs
  task t_byte(input logic [7:0] b, input logic ack);
    apb(1, TWB_DAT_OFS, {24'h0, b});
    apb(1, TWB_CTL_OFS, 32'h40);
    wirq();
    apb(0, TWB_CTL_OFS, 0);
    chk("ack", q[TWB_CTL_ACK], ack);
    chk("byte", rx, b);
  endtask : t_byte
  // Whole write: start, address, data if acked, stop
  task t_xfer(input logic [31:0] cfg, input logic [6:0] a, input int lo);
    int n;
    apb(1, TWB_CFG_OFS, cfg);
    // Foreign START left unfinished: only the free timeout frees the bus
    if (lo > 0) begin
      tb_sda <= 1;
      repeat (4) @(posedge clk);
      tb_scl <= 1;
      repeat (4) @(posedge clk);
      tb_sda <= 0;
      repeat (4) @(posedge clk);
      tb_scl <= 0;
    end
    n = pc;
    apb(1, TWB_CTL_OFS, 32'h20);
    wirq();
    chk("start", (pc - n) inside {[lo:lo + 5]}, 1);
    apb(0, TWB_CTL_OFS, 0);
    chk("master", q[TWB_CTL_MASTER], 1);
    t_byte({a, 1'b0}, a == 7'h2a);
    if (a == 7'h2a) t_byte(8'h3c ^ cfg[7:0], 1);
    apb(1, TWB_CTL_OFS, 32'h50);
    n = 0;
    while (stopped !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("stop", stopped, 1);
    repeat (8) @(posedge clk);
    apb(0, TWB_CFG_OFS, 0);
    chk("busy", q[TWB_CFG_BUSY], 0);
    chk("lines", {scl_oe, sda_oe}, 0);
  endtask : t_xfer
  // Disable in mid-transfer, then the scl-low timer control
  task t_off;
    apb(1, TWB_CTL_OFS, 32'h20);
    wirq();
    apb(1, TWB_CFG_OFS, 0);
    repeat (2) @(posedge clk);
    chk("off", {irq, scl_oe, sda_oe}, 0);
    apb(0, TWB_CTL_OFS, 0);
    chk("ctl", q, 0);
    apb(1, TWB_CFG_OFS, 32'h88);
    tb_scl <= 1;
    repeat (12) @(posedge clk);
    chk("reload", reload, 0);
    tb_scl <= 0;
    repeat (12) @(posedge clk);
    chk("reload", reload, 1);
  endtask : t_off
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tb_scl, tb_sda, ovf, oc, pc, cyc, mismatches, checked} = 0;
    sel = 2'h1;
    repeat (16) @(posedge clk);
    srst <= 0;
    t_regs();
    t_xfer(32'h85, 7'h2a, 10);
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      t_xfer(32'h80 | i, 7'h2a, 0);
    end
    t_xfer(32'h83, 7'h33, 0);
    t_off();
    summarize();
  end
endmodule : twb_ctrl_bench
bind twb_ctrl twb_monitor i_mon (.CLK_SYS, .SRST, .PSEL, .PENABLE,
  .PREADY, .PSLVERR, .SCL_I, .SCL_O, .SDA_O, .SCL_OE, .SDA_OE,
  .TOUT_RELOAD, .IRQ);
`default_nettype wire
